// *** blit_defs.svh ***
// Register indices, field positions and reset values of the block-transfer engine
`ifndef BLIT_DEFS_SVH
`define BLIT_DEFS_SVH
// Register indices; byte address is four times the index
`define IX_CTRL     9'h100
`define IX_FMT      9'h101
`define IX_ROP      9'h102
`define IX_OP       9'h103
`define IX_SRC0     9'h104
`define IX_SRC1     9'h105
`define IX_SRC2     9'h106
`define IX_DST0     9'h108
`define IX_DST1     9'h109
`define IX_DST2     9'h10A
`define IX_STR_LO   9'h10C
`define IX_STR_HI   9'h10D
`define IX_W_LO     9'h110
`define IX_W_HI     9'h111
`define IX_H_LO     9'h112
`define IX_H_HI     9'h113
`define IX_KEY_LO   9'h114
`define IX_KEY_HI   9'h115
// Control register fields
`define CTRL_START  7
`define CTRL_DLIN   0
`define CTRL_SLIN   1
// Operation codes
`define OP_TMOVE    8'h05
`define OP_PATFILL  8'h06
// Colour format codes
`define FMT_8BPP    8'h00
`define FMT_16BPP   8'h01
// Reset values
`define RST_BYTE    8'h00
`define RST_ROP     8'h0C
`endif

// *** blit_pkg.sv ***
// Types shared by the block-transfer engine
package blit_pkg;
  // Engine sequencer states, one-hot
  typedef enum logic [5:0] {
    st_idle  = 6'b000001,
    st_fetch = 6'b000010,
    st_rsrc  = 6'b000100,
    st_rdst  = 6'b001000,
    st_wdst  = 6'b010000,
    st_step  = 6'b100000
  } eng_state_e;
endpackage : blit_pkg

// *** blit_engine.sv ***
// Block-transfer engine: transparent positive move and pattern fill with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "blit_defs.svh"

// Summary of operation
// - Move copies pixels, skipping key-colour source pixels
// - Operation code 05h selects transparent move
// - Addresses only ascend; no negative variant
// - Source, destination each rectangular or linear
// - Both linear bits zero means rectangular
// - Width and height hold count minus one
// - Key colour from background registers, 16-bit at 01h, else low byte
// - Format 01h two-byte pixels, 00h one-byte
// - Line stride register counts 16-bit words
// - Writing 80h to control starts blit
// - Three-byte start addresses, upper-left pixel
// - Pattern fill repeats 8x8 off-screen pattern
// - Pattern combined through 16 raster operations
// - Source address encodes pattern start phase
// - Raster code selects operation; 0Ch copies
// - Control bit 7 reads 1 while active
module blit_engine #(
  parameter int AW = 24                // Display buffer byte address width
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rst_n,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  // Display buffer memory port
  output logic               mem_req,
  output logic               mem_we,
  output logic               mem_wide,
  output logic [AW-1:0]      mem_addr,
  output logic [15:0]        mem_wdata,
  input  wire logic [15:0]   mem_rdata,
  input  wire logic          mem_ack,
  // Status
  output logic               blit_busy
);

  // Registers written by software
  logic          dlin_q;              // Destination linear select
  logic          slin_q;              // Source linear select
  logic [7:0]    fmt_q;               // Colour format
  logic [7:0]    rop_q;               // Raster operation code
  logic [7:0]    op_q;                // Operation select
  logic [23:0]   src_q;               // Source start address
  logic [23:0]   dst_q;               // Destination start address
  logic [15:0]   stride_q;            // Line stride in words
  logic [15:0]   width_q;             // Width minus one
  logic [15:0]   height_q;            // Height minus one
  logic [15:0]   key_q;               // Key colour

  // Engine state
  blit_pkg::eng_state_e state_q;      // Sequencer
  logic          busy_q;              // Engine active
  logic [15:0]   x_q;                 // Column counter
  logic [15:0]   y_q;                 // Row counter
  logic [AW-1:0] sptr_q;              // Current source pixel
  logic [AW-1:0] sline_q;             // Current source line start
  logic [AW-1:0] dptr_q;              // Current destination pixel
  logic [AW-1:0] dline_q;             // Current destination line start
  logic [AW-1:0] pbase_q;             // Pattern base
  logic [2:0]    pcol0_q;             // Pattern phase column
  logic [2:0]    pcol_q;              // Pattern column
  logic [2:0]    prow_q;              // Pattern row
  logic [15:0]   spix_q;              // Source pixel held
  logic          wide_q;              // Two-byte pixels latched
  logic          pat_q;               // Pattern fill latched

  // APB decode
  logic          acc;                 // Access phase, not yet answered
  logic          wr_en;               // Write takes effect
  logic [8:0]    ix;                  // Register index
  logic          hit;                 // Index is mapped
  logic          start;               // Start request accepted

  assign acc   = psel & penable & ~pready;
  assign ix    = paddr[10:2];
  assign wr_en = acc & pwrite & hit;

  // Bitwise raster operation: result bit = code[{s,d}]
  function automatic logic [15:0] rop_apply(input logic [3:0] c,
                                            input logic [15:0] s,
                                            input logic [15:0] d);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[i] = c[{s[i], d[i]}];
    end
    return r;
  endfunction : rop_apply

  // Advance from one line to the next
  function automatic logic [AW-1:0] line_step(input logic lin,
                                              input logic wide,
                                              input logic [15:0] w,
                                              input logic [15:0] str);
    logic [AW-1:0] n;
    n = lin ? AW'({w, 1'b0} + 17'h00002) : AW'({str, 1'b0});
    if (lin && !wide) begin
      n = AW'({1'b0, w} + 17'h00001);
    end
    return n;
  endfunction : line_step

  // Pixel size step in bytes
  function automatic logic [AW-1:0] pix_step(input logic wide);
    return wide ? AW'(2) : AW'(1);
  endfunction : pix_step

  // Mapped index check
  always_comb begin
    case (ix)
      `IX_CTRL, `IX_FMT, `IX_ROP, `IX_OP, `IX_SRC0, `IX_SRC1,
      `IX_SRC2, `IX_DST0, `IX_DST1, `IX_DST2, `IX_STR_LO,
      `IX_STR_HI, `IX_W_LO, `IX_W_HI, `IX_H_LO, `IX_H_HI,
      `IX_KEY_LO, `IX_KEY_HI: hit = ~paddr[11] & (paddr[1:0] == 2'b00);
      default:                hit = 1'b0;
    endcase
  end

  // Start only when idle, with a supported operation
  assign start = wr_en & (ix == `IX_CTRL) & pwdata[`CTRL_START] & ~busy_q
               // Unsupported operation codes leave the engine idle
               & ((op_q == `OP_TMOVE) | (op_q == `OP_PATFILL));

  // APB answer: one wait state, registered
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc;
      pslverr <= acc & ~hit;
      prdata  <= 32'h0000_0000;
      if (acc && !pwrite && hit) begin
        case (ix)
          `IX_CTRL:   prdata[7:0] <= {busy_q, 5'b00000, slin_q, dlin_q};
          `IX_FMT:    prdata[7:0] <= fmt_q;
          `IX_ROP:    prdata[7:0] <= rop_q;
          `IX_OP:     prdata[7:0] <= op_q;
          `IX_SRC0:   prdata[7:0] <= src_q[7:0];
          `IX_SRC1:   prdata[7:0] <= src_q[15:8];
          `IX_SRC2:   prdata[7:0] <= src_q[23:16];
          `IX_DST0:   prdata[7:0] <= dst_q[7:0];
          `IX_DST1:   prdata[7:0] <= dst_q[15:8];
          `IX_DST2:   prdata[7:0] <= dst_q[23:16];
          `IX_STR_LO: prdata[7:0] <= stride_q[7:0];
          `IX_STR_HI: prdata[7:0] <= stride_q[15:8];
          `IX_W_LO:   prdata[7:0] <= width_q[7:0];
          `IX_W_HI:   prdata[7:0] <= width_q[15:8];
          `IX_H_LO:   prdata[7:0] <= height_q[7:0];
          `IX_H_HI:   prdata[7:0] <= height_q[15:8];
          `IX_KEY_LO: prdata[7:0] <= key_q[7:0];
          `IX_KEY_HI: prdata[7:0] <= key_q[15:8];
          default:    prdata[7:0] <= 8'h00;
        endcase
      end
    end
  end

  // Setup register writes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dlin_q   <= 1'b0;
      slin_q   <= 1'b0;
      fmt_q    <= `RST_BYTE;
      rop_q    <= `RST_ROP;
      op_q     <= `RST_BYTE;
      src_q    <= 24'h00_0000;
      dst_q    <= 24'h00_0000;
      stride_q <= 16'h0000;
      width_q  <= 16'h0000;
      height_q <= 16'h0000;
      key_q    <= 16'h0000;
    end else if (wr_en) begin
      case (ix)
        `IX_CTRL: begin
          dlin_q <= pwdata[`CTRL_DLIN];
          slin_q <= pwdata[`CTRL_SLIN];
        end
        `IX_FMT:    fmt_q           <= pwdata[7:0];
        `IX_ROP:    rop_q           <= pwdata[7:0];
        `IX_OP:     op_q            <= pwdata[7:0];
        `IX_SRC0:   src_q[7:0]      <= pwdata[7:0];
        `IX_SRC1:   src_q[15:8]     <= pwdata[7:0];
        `IX_SRC2:   src_q[23:16]    <= pwdata[7:0];
        `IX_DST0:   dst_q[7:0]      <= pwdata[7:0];
        `IX_DST1:   dst_q[15:8]     <= pwdata[7:0];
        `IX_DST2:   dst_q[23:16]    <= pwdata[7:0];
        `IX_STR_LO: stride_q[7:0]   <= pwdata[7:0];
        `IX_STR_HI: stride_q[15:8]  <= pwdata[7:0];
        `IX_W_LO:   width_q[7:0]    <= pwdata[7:0];
        `IX_W_HI:   width_q[15:8]   <= pwdata[7:0];
        `IX_H_LO:   height_q[7:0]   <= pwdata[7:0];
        `IX_H_HI:   height_q[15:8]  <= pwdata[7:0];
        `IX_KEY_LO: key_q[7:0]      <= pwdata[7:0];
        `IX_KEY_HI: key_q[15:8]     <= pwdata[7:0];
        default:    op_q            <= op_q;
      endcase
    end
  end

  // Key match on the fetched source pixel
  logic key_hit;
  assign key_hit = wide_q ? (mem_rdata == key_q)
                          : (mem_rdata[7:0] == key_q[7:0]);

  // Pattern pixel address: base plus (row*8+col) pixels
  logic [AW-1:0] pat_addr;
  assign pat_addr = pbase_q
                  + (wide_q ? AW'({prow_q, pcol_q, 1'b0})
                            : AW'({prow_q, pcol_q}));

  // Last pixel of the line and of the area
  logic end_x;
  logic end_y;
  assign end_x = (x_q == width_q);
  assign end_y = (y_q == height_q);

  // Sequencer and memory port
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q   <= blit_pkg::st_idle;
      busy_q    <= 1'b0;
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_wide  <= 1'b0;
      mem_addr  <= '0;
      mem_wdata <= 16'h0000;
      spix_q    <= 16'h0000;
    end else begin
      case (state_q)
        // Wait for a start command
        blit_pkg::st_idle: begin
          if (start) begin
            busy_q  <= 1'b1;
            state_q <= blit_pkg::st_fetch;
          end
        end
        // Issue the source or pattern read
        blit_pkg::st_fetch: begin
          mem_req  <= 1'b1;
          mem_we   <= 1'b0;
          mem_wide <= wide_q;
          mem_addr <= pat_q ? pat_addr : sptr_q;
          state_q  <= blit_pkg::st_rsrc;
        end
        // Source pixel arrives
        blit_pkg::st_rsrc: begin
          if (mem_ack) begin
            spix_q <= mem_rdata;
            if (pat_q) begin
              mem_addr <= dptr_q;
              state_q  <= blit_pkg::st_rdst;
            end else if (key_hit) begin
              mem_req  <= 1'b0;
              state_q  <= blit_pkg::st_step;
            end else begin
              mem_we    <= 1'b1;
              mem_addr  <= dptr_q;
              mem_wdata <= mem_rdata;
              state_q   <= blit_pkg::st_wdst;
            end
          end
        end
        // Destination pixel arrives; combine and write
        blit_pkg::st_rdst: begin
          if (mem_ack) begin
            mem_we    <= 1'b1;
            mem_wdata <= rop_apply(rop_q[3:0], spix_q, mem_rdata);
            state_q   <= blit_pkg::st_wdst;
          end
        end
        // Write completes
        blit_pkg::st_wdst: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we  <= 1'b0;
            state_q <= blit_pkg::st_step;
          end
        end
        // Advance or finish
        blit_pkg::st_step: begin
          if (end_x && end_y) begin
            busy_q  <= 1'b0;
            state_q <= blit_pkg::st_idle;
          end else begin
            state_q <= blit_pkg::st_fetch;
          end
        end
        default: begin
          busy_q  <= 1'b0;
          mem_req <= 1'b0;
          state_q <= blit_pkg::st_idle;
        end
      endcase
    end
  end

  // Walk counters and pointers, ascending only
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      x_q     <= 16'h0000;
      y_q     <= 16'h0000;
      sptr_q  <= '0;
      sline_q <= '0;
      dptr_q  <= '0;
      dline_q <= '0;
      pbase_q <= '0;
      pcol0_q <= 3'b000;
      pcol_q  <= 3'b000;
      prow_q  <= 3'b000;
      wide_q  <= 1'b0;
      pat_q   <= 1'b0;
    end else if (state_q == blit_pkg::st_idle && start) begin
      x_q     <= 16'h0000;
      y_q     <= 16'h0000;
      sptr_q  <= AW'(src_q);
      sline_q <= AW'(src_q);
      dptr_q  <= AW'(dst_q);
      dline_q <= AW'(dst_q);
      wide_q  <= (fmt_q == `FMT_16BPP);
      pat_q   <= (op_q == `OP_PATFILL);
      if (fmt_q == `FMT_16BPP) begin
        pbase_q <= AW'({src_q[23:7], 7'h00});
        pcol0_q <= src_q[3:1];
        pcol_q  <= src_q[3:1];
        prow_q  <= src_q[6:4];
      end else begin
        pbase_q <= AW'({src_q[23:6], 6'h00});
        pcol0_q <= src_q[2:0];
        pcol_q  <= src_q[2:0];
        prow_q  <= src_q[5:3];
      end
    end else if (state_q == blit_pkg::st_step && !(end_x && end_y)) begin
      if (!end_x) begin
        x_q    <= x_q + 16'h0001;
        sptr_q <= sptr_q + pix_step(wide_q);
        dptr_q <= dptr_q + pix_step(wide_q);
        pcol_q <= pcol_q + 3'b001;
      end else begin
        x_q     <= 16'h0000;
        y_q     <= y_q + 16'h0001;
        sline_q <= sline_q + line_step(slin_q, wide_q, width_q, stride_q);
        sptr_q  <= sline_q + line_step(slin_q, wide_q, width_q, stride_q);
        dline_q <= dline_q + line_step(dlin_q, wide_q, width_q, stride_q);
        dptr_q  <= dline_q + line_step(dlin_q, wide_q, width_q, stride_q);
        pcol_q  <= pcol0_q;
        prow_q  <= prow_q + 3'b001;
      end
    end
  end

  // Status output
  assign blit_busy = busy_q;

endmodule : blit_engine
`default_nettype wire

// *** blit_engine_assertions.sv ***
// Port checker for the block-transfer engine
`timescale 1ns/1ps
`default_nettype none
`include "blit_defs.svh"
module blit_checker #(
  parameter int AW = 24            // Memory address width
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rst_n,
  // APB side
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic          pready,
  input  wire logic [31:0]   prdata,
  input  wire logic          pslverr,
  // Memory side and status
  input  wire logic          mem_req,
  input  wire logic          mem_we,
  input  wire logic          mem_wide,
  input  wire logic [AW-1:0] mem_addr,
  input  wire logic [15:0]   mem_wdata,
  input  wire logic [15:0]   mem_rdata,
  input  wire logic          mem_ack,
  input  wire logic          blit_busy
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  logic acc;  // Access phase still waiting for its answer
  logic go;   // Start bit written in that phase
  assign acc = psel && penable && !pready;
  assign go  = acc && pwrite && paddr[10:2] == `IX_CTRL && pwdata[`CTRL_START];
  property p_ans; acc |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer one cycle after access");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready stood longer than one cycle");
  property p_cause; pready |-> $past(acc); endproperty
  a_cause: assert property (p_cause) else $error("ready without access phase");
  property p_err; acc && paddr[10:2] == 9'h107 |=> pslverr && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_hi; pready |-> prdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("read data upper bits not zero");
  property p_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wide);
  endproperty
  a_hold: assert property (p_hold) else $error("memory request changed before acknowledge");
  property p_busy; mem_req |-> blit_busy; endproperty
  a_busy: assert property (p_busy) else $error("memory access while idle");
  property p_go; $rose(blit_busy) |-> $past(go) || $past(go, 2); endproperty
  a_go: assert property (p_go) else $error("engine started without start write");
  property p_stat;
    pready && !pslverr && !pwrite && paddr[10:2] == `IX_CTRL |-> prdata[7] == $past(blit_busy);
  endproperty
  a_stat: assert property (p_stat) else $error("control bit 7 differs from busy");
endmodule : blit_checker
bind blit_engine blit_checker #(.AW(AW)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .mem_req(mem_req), .mem_we(mem_we), .mem_wide(mem_wide), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .blit_busy(blit_busy)
);
`default_nettype wire

// *** mem_model.sv ***
// Display memory model answering the engine's pixel accesses
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  // Clock, reset and answer delay
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  lat,
  // Engine memory port
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic        mem_wide,
  input  wire logic [23:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic      [15:0] mem_rdata,
  output logic             mem_ack
);
  logic [7:0] m [int];  // Byte store, absent bytes read as zero
  logic [3:0] cnt_q;    // Cycles the request has waited
  logic [7:0] noise_q;  // Filler for lanes that carry no data
  // Look up one byte
  function automatic logic [7:0] rd(input logic [23:0] a);
    return m.exists(int'(a)) ? m[int'(a)] : 8'h00;
  endfunction : rd
  // Answer each request after lat cycles with a one-cycle acknowledge
  always @(posedge mclk) begin
    noise_q <= noise_q + 8'h3B;
    if (!rst_n) begin
      mem_ack   <= 1'b0;
      cnt_q     <= 4'h0;
      noise_q   <= 8'h5A;
      mem_rdata <= 16'h0;
    end else if (mem_ack) begin
      // Data lanes go stale once the acknowledge is gone
      mem_ack   <= 1'b0;
      cnt_q     <= 4'h0;
      mem_rdata <= {noise_q, ~noise_q};
    end else if (mem_req && cnt_q >= lat) begin
      mem_ack <= 1'b1;
      if (mem_we) begin
        m[int'(mem_addr)] = mem_wdata[7:0];
        if (mem_wide) m[int'(mem_addr) + 1] = mem_wdata[15:8];
        mem_rdata <= {~noise_q, noise_q};
      end else begin
        mem_rdata <= {mem_wide ? rd(mem_addr + 24'h1) : noise_q, rd(mem_addr)};
      end
    end else if (mem_req) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : mem_model
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the block-transfer engine
`timescale 1ns/1ps
`default_nettype none
`include "blit_defs.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb;
  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr;  // Clock, reset, APB
  logic [11:0] paddr;                                                // APB byte address
  logic [31:0] pwdata, prdata;                                       // APB data
  logic        mem_req, mem_we, mem_wide, mem_ack, blit_busy;        // Memory, status
  logic [23:0] mem_addr;                                             // Memory address
  logic [15:0] mem_wdata, mem_rdata;                                 // Memory data
  logic [3:0]  lat;                                                  // Memory delay
  logic [7:0]  rv;                                                   // Last read value
  logic        re;                                                   // Last slave error
  int          error_cnt, samples_checked, cyc;                      // Counters
  localparam logic [7:0] pat_v = 8'hCC, dst_v = 8'hAA;               // Operand bytes
  typedef struct {logic [8:0] ix; logic [7:0] wd; logic [7:0] rst_v;} row_s;
  row_s rows [18] = '{'{`IX_CTRL, 8'h00, 8'h00}, '{`IX_FMT, 8'h01, 8'h00},
    '{`IX_ROP, 8'h3A, 8'h0C}, '{`IX_OP, 8'h06, 8'h00}, '{`IX_SRC0, 8'hC8, 8'h00},
    '{`IX_SRC1, 8'h32, 8'h00}, '{`IX_SRC2, 8'h10, 8'h00}, '{`IX_DST0, 8'h90, 8'h00},
    '{`IX_DST1, 8'h65, 8'h00}, '{`IX_DST2, 8'h0F, 8'h00}, '{`IX_STR_LO, 8'h80, 8'h00},
    '{`IX_STR_HI, 8'h02, 8'h00}, '{`IX_W_LO, 8'h08, 8'h00}, '{`IX_W_HI, 8'h01, 8'h00},
    '{`IX_H_LO, 8'h40, 8'h00}, '{`IX_H_HI, 8'hFF, 8'h00}, '{`IX_KEY_LO, 8'h1F, 8'h00},
    '{`IX_KEY_HI, 8'hA5, 8'h00}};
  // Print counts and verdict, then stop
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  // One APB transfer, entered just after a rising edge
  task automatic bus(input logic wr, input logic [8:0] ix, input logic [7:0] wd);
    psel <= 1'b1; pwrite <= wr; paddr <= {1'b0, ix, 2'b00}; pwdata <= {24'h0, wd};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // Wait for the answer; only the bench timeout ends a hang here
    while (pready !== 1'b1) @(posedge mclk);
    rv = prdata[7:0];
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : bus
  // Program every setup register, start, and wait for completion
  task automatic blit(input logic [7:0] f, o, r, input logic [23:0] s, d,
                      input logic [15:0] w, h, k, input logic [1:0] ln);
    logic [8:0] ix [17];
    logic [7:0] v [17];
    int n;
    ix = '{`IX_FMT, `IX_OP, `IX_ROP, `IX_SRC0, `IX_SRC1, `IX_SRC2, `IX_DST0, `IX_DST1, `IX_DST2,
           `IX_STR_LO, `IX_STR_HI, `IX_W_LO, `IX_W_HI, `IX_H_LO, `IX_H_HI, `IX_KEY_LO, `IX_KEY_HI};
    v = '{f, o, r, s[7:0], s[15:8], s[23:16], d[7:0], d[15:8], d[23:16], 8'h08, 8'h00,
          w[7:0], w[15:8], h[7:0], h[15:8], k[7:0], k[15:8]};
    foreach (ix[i]) bus(1'b1, ix[i], v[i]);
    bus(1'b1, `IX_CTRL, {6'b100000, ln});
    bus(1'b0, `IX_CTRL, 8'h00);
    `CHK("busy bit", o == `OP_TMOVE || o == `OP_PATFILL, rv[7])
    `CHK("linear bits", ln, rv[1:0])
    n = 0;
    while (blit_busy !== 1'b0 && n < 3000) begin @(posedge mclk); n++; end
    `CHK("busy end", 1'b0, blit_busy)
    $display("blit op %0h rop %0h done", o, r);
  endtask : blit
  // Transparent move of 3x2 pixels with key pixels in the source
  task automatic mv(input logic wd, input logic [1:0] ln, input logic [15:0] k,
                    input logic [3:0] l);
    int b, ss, ds, a;
    logic [15:0] p;
    logic [15:0] ex [6];
    b  = wd ? 2 : 1;
    ss = ln[1] ? 3 * b : 16;
    ds = ln[0] ? 3 * b : 16;
    lat <= l;
    for (int q = 0; q < 6; q++) begin
      p = (q == 1 || q == 5) ? k : (q == 2) ? {~k[15:8], k[7:0]} : {8'h30 + 8'(q), 8'h60 + 8'(q)};
      for (int j = 0; j < b; j++) begin
        mem.m[256 + (q / 3) * ss + (q % 3) * b + j] = p[8 * j +: 8];
        mem.m[512 + (q / 3) * ds + (q % 3) * b + j] = 8'hEE;
      end
      ex[q] = (wd ? p == k : p[7:0] == k[7:0]) ? 16'hEEEE : {wd ? p[15:8] : 8'hEE, p[7:0]};
    end
    blit({7'h0, wd}, `OP_TMOVE, 8'h0C, 24'h100, 24'h200, 16'd2, 16'd1, k, ln);
    for (int q = 0; q < 6; q++) begin
      a = 512 + (q / 3) * ds + (q % 3) * b;
      `CHK("move px", ex[q], {wd ? mem.rd(24'(a + 1)) : 8'hEE, mem.rd(24'(a))})
    end
  endtask : mv
  // Pattern fill of 3x2 pixels from phase column 6, row 7
  task automatic pf(input logic wd);
    int b, i, a;
    b = wd ? 2 : 1;
    lat <= 4'd2;
    for (int j = 0; j < 64 * b; j++) mem.m[1024 + j] = 8'h80 + 8'(j);
    blit({7'h0, wd}, `OP_PATFILL, 8'h0C, 24'(1024 + 62 * b), 24'h300, 16'd2, 16'd1, 16'h0,
         2'b00);
    for (int q = 0; q < 6; q++) begin
      i = ((7 + q / 3) % 8) * 8 + (6 + q % 3) % 8;
      a = 768 + (q / 3) * 16 + (q % 3) * b;
      `CHK("fill px", {wd ? 8'h81 + 8'(i * b) : 8'h00, 8'h80 + 8'(i * b)},
           {wd ? mem.rd(24'(a + 1)) : 8'h00, mem.rd(24'(a))})
    end
  endtask : pf
  // Design under test and memory partner
  blit_engine DUT (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .mem_req(mem_req), .mem_we(mem_we), .mem_wide(mem_wide), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .blit_busy(blit_busy));
  mem_model mem (.mclk(mclk), .rst_n(rst_n), .lat(lat), .mem_req(mem_req), .mem_we(mem_we),
    .mem_wide(mem_wide), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));
  // Clock of 8 ns
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Cut a hang short
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin error_cnt++; summarize(); end
  end
  // Main sequence
  initial begin
    logic [7:0] e;
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h0; pwdata = 32'h0; lat = 4'd3;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    foreach (rows[i]) begin
      bus(1'b0, rows[i].ix, 8'h00);
      `CHK("reset value", rows[i].rst_v, rv)
      bus(1'b1, rows[i].ix, rows[i].wd);
      bus(1'b0, rows[i].ix, 8'h00);
      `CHK("read back", rows[i].wd, rv)
    end
    bus(1'b1, 9'h107, 8'h5A);
    `CHK("unmapped err", 1'b1, re)
    bus(1'b0, 9'h107, 8'h00);
    `CHK("unmapped data", 8'h00, rv)
    $display("register table done");
    mv(1'b1, 2'b00, 16'h001F, 4'd3);
    mv(1'b0, 2'b01, 16'h551F, 4'd0);
    mv(1'b1, 2'b10, 16'h001F, 4'd5);
    pf(1'b0);
    pf(1'b1);
    lat <= 4'd4;
    for (int o = 0; o < 16; o++) begin
      mem.m[1280] = pat_v;
      mem.m[1536] = dst_v;
      blit(8'h00, `OP_PATFILL, 8'(o), 24'd1280, 24'd1536, 16'd0, 16'd0, 16'd0, 2'b00);
      for (int i = 0; i < 8; i++) e[i] = o[{pat_v[i], dst_v[i]}];
      `CHK("rop result", e, mem.rd(24'd1536))
    end
    blit(8'h00, 8'h03, 8'h0C, 24'h0, 24'h0, 16'd0, 16'd0, 16'd0, 2'b00);
    // Reset in mid-blit: engine stops and registers return to reset values
    bus(1'b1, `IX_OP, `OP_PATFILL);
    bus(1'b1, `IX_W_LO, 8'h07);
    bus(1'b1, `IX_CTRL, 8'h80);
    repeat (3) @(posedge mclk);
    `CHK("busy before reset", 1'b1, blit_busy)
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    `CHK("reset busy", 1'b0, blit_busy)
    `CHK("reset req", 1'b0, mem_req)
    rst_n <= 1'b1;
    @(posedge mclk);
    bus(1'b0, `IX_ROP, 8'h00);
    `CHK("reset rop", `RST_ROP, rv)
    bus(1'b0, `IX_OP, 8'h00);
    `CHK("reset op", `RST_BYTE, rv)
    $display("mid-run reset done");
    summarize();
  end
endmodule : tb
`default_nettype wire
